//--- rtl/fsfs_pkg.sv
// Constants and types for the fan supervisor fault sequencer
// Function
// - Blank sense pulses caused by drive turn-on
// - 32 cycles without pulse starts diagnostic timer
// - Diagnostic holds drive on three cycles
// - No pulse in diagnostic: 32-cycle full-on retry
// - Retry timeout: stop drive, fault low, latch
// - Fan fault keeps fault low, drive off
// - Only shutdown-release or power cycle clears latch
// - Over-temperature asserts fault in run, diagnostic and retry while level exceeds threshold
// - Over-temperature never stops or latches drive
// - Power-up drives fan 32 cycles, pulse ends early
// - Second 32-cycle start, then fan fault
// - Power-up waits for release above threshold
// - Each pulse restarts missing-pulse count
// - Shutdown: zero duty, fault inactive, restart fresh
// - Run duty follows greater control level
// - Sequencer timers advance once per PWM cycle; blanking timer counts clocks
// - Short shutdown pulse resets and restarts
// - Shutdown resets the sequencer timer and fault latch
// - Start-up period also after leaving shutdown
package fsfs_pkg;

  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int CLK_FREQ_MHZ = 20;
  localparam int PWM_FREQ_HZ = 30;
  localparam int PWM_STEPS = 256;
  localparam int PWM_STEP_CLKS = CLK_FREQ_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam int BLANK_TIME_US = 100;
  localparam int BLANK_CLKS = BLANK_TIME_US * CLK_FREQ_MHZ;
  localparam int LEVEL_W = 8;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] STARTUP_CYCLES = 6'h20;
  localparam logic [CNT_W-1:0] MISS_CYCLES = 6'h20;
  localparam logic [CNT_W-1:0] DIAG_CYCLES = 6'h03;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

  typedef enum logic [2:0] {
    ST_SHDN,
    ST_START1,
    ST_START2,
    ST_RUN,
    ST_DIAG,
    ST_RETRY,
    ST_FAULT
  } fsfs_state_e;

  // Synchronised comparator results
  typedef struct packed {
    logic sense;
    logic shutdown;
    logic release_ok;
    logic overtemp;
  } fsfs_cmp_s;

endpackage : fsfs_pkg

//--- rtl/fsfs_sync.sv
// Three-stage synchroniser with agreement filter per bit
`timescale 1ns/10ps
module fsfs_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous inputs and filtered result
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      logic out_next;

      // Stage one feeds only stage two
      always_comb
      begin
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          out_reg <= out_next;
        end
      end

      assign sync_out[i] = out_reg;
    end
  endgenerate

endmodule : fsfs_sync

//--- rtl/fsfs_pwm.sv
// PWM timebase and drive comparator
`timescale 1ns/10ps
module fsfs_pwm #(
  parameter int STEP_CLKS = fsfs_pkg::PWM_STEP_CLKS,
  parameter int LEVEL_W = fsfs_pkg::LEVEL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Drive control
  input wire logic [LEVEL_W-1:0] duty,
  input wire logic force_on,
  input wire logic force_off,
  // Cycle start pulse and drive
  output logic tick,
  output logic drive
);

  localparam int STEP_W = $clog2(STEP_CLKS + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CLKS - 1);
  localparam logic [LEVEL_W-1:0] FULL = '1;

  logic [STEP_W-1:0] step_reg;
  logic [STEP_W-1:0] step_next;
  logic [LEVEL_W-1:0] phase_reg;
  logic [LEVEL_W-1:0] phase_next;
  logic tick_reg;
  logic tick_next;
  logic drive_reg;
  logic drive_next;

  always_comb
  begin
    step_next = step_reg + 1'b1;
    phase_next = phase_reg;
    tick_next = 1'b0;
    if (step_reg == STEP_LAST)
    begin
      step_next = '0;
      phase_next = phase_reg + 1'b1;
      tick_next = (phase_reg == FULL);
    end
    // Full level gives a solid drive, no one-step gap
    if (force_off)
      drive_next = 1'b0;
    else if (force_on || duty == FULL)
      drive_next = 1'b1;
    else
      drive_next = (phase_next < duty);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_reg <= '0;
      phase_reg <= '0;
      tick_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else
    begin
      step_reg <= step_next;
      phase_reg <= phase_next;
      tick_reg <= tick_next;
      drive_reg <= drive_next;
    end
  end

  assign tick = tick_reg;
  assign drive = drive_reg;

endmodule : fsfs_pwm

//--- rtl/fsfs_top.sv
// Fan supervisor: start-up, missing pulse, diagnostic and fault sequencing
`timescale 1ns/10ps
module fsfs_top #(
  parameter int PWM_STEP_CLKS = fsfs_pkg::PWM_STEP_CLKS,
  parameter int BLANK_CLKS = fsfs_pkg::BLANK_CLKS,
  parameter int LEVEL_W = fsfs_pkg::LEVEL_W
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Digitised control levels
  input wire logic [LEVEL_W-1:0] TEMP_CONTROL_LEVEL,
  input wire logic [LEVEL_W-1:0] MIN_SPEED_LEVEL,
  // Comparator results from the analog front end
  input wire logic SENSE_PULSE,
  input wire logic SHUTDOWN_CMP,
  input wire logic RELEASE_CMP,
  input wire logic OVERTEMP_CMP,
  // Fan drive and open-drain fault pin
  output logic FAN_DRIVE_OUT,
  output logic FAULT_N_O,
  output logic FAULT_N_OE
);

  localparam int BLANK_W = $clog2(BLANK_CLKS + 1);
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CLKS);

  fsfs_pkg::fsfs_cmp_s cmp;
  logic [2*LEVEL_W-1:0] lvl_sync;
  logic [LEVEL_W-1:0] temp_lvl;
  logic [LEVEL_W-1:0] min_lvl;
  logic pwm_tick;
  logic pwm_drive;
  logic [LEVEL_W-1:0] duty;
  logic force_on;
  logic force_off;

  // Comparators and levels all cross in from outside the clock domain
  fsfs_sync #(
    .WIDTH(4)
  ) u_cmp_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .async_in({SENSE_PULSE, SHUTDOWN_CMP, RELEASE_CMP, OVERTEMP_CMP}),
    .sync_out(cmp)
  );

  fsfs_sync #(
    .WIDTH(2 * LEVEL_W)
  ) u_lvl_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .async_in({TEMP_CONTROL_LEVEL, MIN_SPEED_LEVEL}),
    .sync_out(lvl_sync)
  );

  // Word taken after two equal samples; hides one-clock bit skew
  // Skew beyond a clock would need a handshake
  logic [2*LEVEL_W-1:0] lvl_prev_reg;
  logic [2*LEVEL_W-1:0] lvl_prev_next;
  logic [2*LEVEL_W-1:0] lvl_hold_reg;
  logic [2*LEVEL_W-1:0] lvl_hold_next;

  always_comb
  begin
    lvl_prev_next = lvl_sync;
    lvl_hold_next = lvl_hold_reg;
    if (lvl_sync == lvl_prev_reg)
      lvl_hold_next = lvl_sync;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lvl_prev_reg <= '0;
      lvl_hold_reg <= '0;
    end
    else
    begin
      lvl_prev_reg <= lvl_prev_next;
      lvl_hold_reg <= lvl_hold_next;
    end
  end

  assign temp_lvl = lvl_hold_reg[2*LEVEL_W-1:LEVEL_W];
  assign min_lvl = lvl_hold_reg[LEVEL_W-1:0];

  fsfs_pwm #(
    .STEP_CLKS(PWM_STEP_CLKS),
    .LEVEL_W(LEVEL_W)
  ) u_pwm (
    .clk(MCLK),
    .rst_n(RST_N),
    .duty(duty),
    .force_on(force_on),
    .force_off(force_off),
    .tick(pwm_tick),
    .drive(pwm_drive)
  );

  // Shutdown hold with hysteresis between the two thresholds
  logic shdn_reg;
  logic shdn_next;

  always_comb
  begin
    shdn_next = shdn_reg;
    if (cmp.shutdown)
      shdn_next = 1'b1;
    else if (cmp.release_ok)
      shdn_next = 1'b0;
  end

  // Turn-on blanking of sense pulses
  logic drive_prev_reg;
  logic drive_prev_next;
  logic [BLANK_W-1:0] blank_reg;
  logic [BLANK_W-1:0] blank_next;
  logic sense_prev_reg;
  logic sense_prev_next;
  logic pulse;

  always_comb
  begin
    drive_prev_next = pwm_drive;
    sense_prev_next = cmp.sense;
    blank_next = blank_reg;
    if (pwm_drive && !drive_prev_reg)
      blank_next = BLANK_LOAD;
    else if (blank_reg != '0)
      blank_next = blank_reg - 1'b1;
  end

  // Only edges outside the turn-on window count as commutation
  assign pulse = cmp.sense && !sense_prev_reg && (blank_reg == '0);

  // Sequencer
  fsfs_pkg::fsfs_state_e state_reg;
  fsfs_pkg::fsfs_state_e state_next;
  logic [fsfs_pkg::CNT_W-1:0] cnt_reg;
  logic [fsfs_pkg::CNT_W-1:0] cnt_next;
  logic [fsfs_pkg::CNT_W-1:0] cnt_inc;
  logic fault_reg;
  logic fault_next;

  assign cnt_inc = cnt_reg + 1'b1;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    // Timers move only on the PWM cycle tick
    if (pwm_tick)
      cnt_next = cnt_inc;
    case (state_reg)
      fsfs_pkg::ST_SHDN:
      begin
        cnt_next = fsfs_pkg::CNT_RESET;
        if (!shdn_reg)
          state_next = fsfs_pkg::ST_START1;
      end
      fsfs_pkg::ST_START1:
      begin
        if (pulse)
        begin
          state_next = fsfs_pkg::ST_RUN;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
        else if (pwm_tick && cnt_inc == fsfs_pkg::STARTUP_CYCLES)
        begin
          state_next = fsfs_pkg::ST_START2;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
      end
      fsfs_pkg::ST_START2:
      begin
        if (pulse)
        begin
          state_next = fsfs_pkg::ST_RUN;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
        else if (pwm_tick && cnt_inc == fsfs_pkg::STARTUP_CYCLES)
          state_next = fsfs_pkg::ST_FAULT;
      end
      fsfs_pkg::ST_RUN:
      begin
        // A pulse on a tick still restarts the count
        if (pulse)
          cnt_next = fsfs_pkg::CNT_RESET;
        else if (pwm_tick && cnt_inc == fsfs_pkg::MISS_CYCLES)
        begin
          state_next = fsfs_pkg::ST_DIAG;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
      end
      fsfs_pkg::ST_DIAG:
      begin
        if (pulse)
        begin
          state_next = fsfs_pkg::ST_RUN;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
        else if (pwm_tick && cnt_inc == fsfs_pkg::DIAG_CYCLES)
        begin
          state_next = fsfs_pkg::ST_RETRY;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
      end
      fsfs_pkg::ST_RETRY:
      begin
        if (pulse)
        begin
          state_next = fsfs_pkg::ST_RUN;
          cnt_next = fsfs_pkg::CNT_RESET;
        end
        else if (pwm_tick && cnt_inc == fsfs_pkg::STARTUP_CYCLES)
          state_next = fsfs_pkg::ST_FAULT;
      end
      fsfs_pkg::ST_FAULT:
      begin
        // Latched; only the shutdown override below leaves
        cnt_next = fsfs_pkg::CNT_RESET;
      end
      default:
      begin
        state_next = fsfs_pkg::ST_SHDN;
        cnt_next = fsfs_pkg::CNT_RESET;
      end
    endcase
    // Any shutdown, however short once filtered, restarts from scratch
    if (shdn_reg || cmp.shutdown)
    begin
      state_next = fsfs_pkg::ST_SHDN;
      cnt_next = fsfs_pkg::CNT_RESET;
    end
  end

  // Drive selection per state
  always_comb
  begin
    duty = '0;
    force_on = 1'b0;
    force_off = 1'b0;
    case (state_reg)
      fsfs_pkg::ST_RUN:
        duty = (temp_lvl > min_lvl) ? temp_lvl : min_lvl;
      fsfs_pkg::ST_START1,
      fsfs_pkg::ST_START2,
      fsfs_pkg::ST_RETRY:
        force_on = 1'b1;
      fsfs_pkg::ST_DIAG:
        force_on = 1'b1;
      default:
        force_off = 1'b1;
    endcase
  end

  // Fault pin: latched in fan fault, follows over-temperature in operation
  always_comb
  begin
    case (state_next)
      fsfs_pkg::ST_FAULT:
        fault_next = 1'b1;
      fsfs_pkg::ST_RUN,
      fsfs_pkg::ST_DIAG,
      fsfs_pkg::ST_RETRY:
        fault_next = cmp.overtemp;
      default:
        fault_next = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      shdn_reg <= 1'b1;
      drive_prev_reg <= 1'b0;
      sense_prev_reg <= 1'b0;
      blank_reg <= '0;
      state_reg <= fsfs_pkg::ST_SHDN;
      cnt_reg <= fsfs_pkg::CNT_RESET;
      fault_reg <= 1'b0;
    end
    else
    begin
      shdn_reg <= shdn_next;
      drive_prev_reg <= drive_prev_next;
      sense_prev_reg <= sense_prev_next;
      blank_reg <= blank_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fault_reg <= fault_next;
    end
  end

  assign FAN_DRIVE_OUT = pwm_drive;
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE = fault_reg;

endmodule : fsfs_top

//--- tb/fsfs_properties.sv
// Port checker for the fan supervisor
`timescale 1ns/10ps
module fsfs_properties #(
  parameter int PWM_STEP_CLKS = 1,
  parameter int BLANK_CLKS = 8,
  parameter int LEVEL_W = 8
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Levels and comparators
  input wire logic [LEVEL_W-1:0] TEMP_CONTROL_LEVEL,
  input wire logic [LEVEL_W-1:0] MIN_SPEED_LEVEL,
  input wire logic SENSE_PULSE,
  input wire logic SHUTDOWN_CMP,
  input wire logic RELEASE_CMP,
  input wire logic OVERTEMP_CMP,
  // Drive and fault pin
  input wire logic FAN_DRIVE_OUT,
  input wire logic FAULT_N_O,
  input wire logic FAULT_N_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  reset_idle_a: assert property (
    $rose(RST_N) |-> !FAN_DRIVE_OUT && !FAULT_N_OE)
    else $error("outputs active after reset");
  pin_low_a: assert property (!FAULT_N_O)
    else $error("fault pin data not low");
  shdn_drive_a: assert property (
    SHUTDOWN_CMP[*8] |=> !FAN_DRIVE_OUT)
    else $error("drive on in shutdown");
  shdn_fault_a: assert property (
    SHUTDOWN_CMP[*8] |=> !FAULT_N_OE)
    else $error("fault active in shutdown");
  hold_shdn_a: assert property (
    SHUTDOWN_CMP[*8] ##1 (!RELEASE_CMP && !SHUTDOWN_CMP)[*8]
    |=> !FAN_DRIVE_OUT)
    else $error("start before release");
  start_drive_a: assert property (
    SHUTDOWN_CMP[*8] ##1 (RELEASE_CMP && !SHUTDOWN_CMP)[*8]
    |=> FAN_DRIVE_OUT[*8])
    else $error("no start drive after release");
  fan_hold_a: assert property (
    (!OVERTEMP_CMP && !SHUTDOWN_CMP)[*8] ##0 (FAULT_N_OE && !FAN_DRIVE_OUT)
    |=> FAULT_N_OE && !FAN_DRIVE_OUT)
    else $error("fan fault not held");
  ot_fault_a: assert property (
    $rose(FAULT_N_OE) ##1 FAN_DRIVE_OUT |-> OVERTEMP_CMP)
    else $error("fault raised while driving without overtemp");
endmodule : fsfs_properties

bind fsfs_top fsfs_properties #(.PWM_STEP_CLKS(PWM_STEP_CLKS),
  .BLANK_CLKS(BLANK_CLKS), .LEVEL_W(LEVEL_W)) i_props (.MCLK(MCLK),
  .RST_N(RST_N), .TEMP_CONTROL_LEVEL(TEMP_CONTROL_LEVEL),
  .MIN_SPEED_LEVEL(MIN_SPEED_LEVEL), .SENSE_PULSE(SENSE_PULSE),
  .SHUTDOWN_CMP(SHUTDOWN_CMP), .RELEASE_CMP(RELEASE_CMP),
  .OVERTEMP_CMP(OVERTEMP_CMP), .FAN_DRIVE_OUT(FAN_DRIVE_OUT),
  .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE));

//--- tb/fsfs_fan_model.sv
// Behavioural fan and sense network
`timescale 1ns/10ps
module fsfs_fan_model (
  // Clock and drive
  input wire logic clk,
  input wire logic drive,
  // Rotor enable and sense comparator
  input wire logic spin_en,
  output logic sense
);
  logic [7:0] on_reg;

  // Wrap to 8'h80 so no false turn-on spike appears while held on
  always_ff @(posedge clk)
  begin
    if (drive !== 1'b1)
      on_reg <= 8'h00;
    else if (on_reg == 8'hff)
      on_reg <= 8'h80;
    else
      on_reg <= on_reg + 8'h01;
  end

  // Spike at every turn-on, rotor pulses only while spinning
  assign sense = drive && (on_reg < 8'h04 || (spin_en &&
    on_reg[6:0] >= 7'h50 && on_reg[6:0] < 7'h54));
endmodule : fsfs_fan_model

//--- tb/tb.sv
// Bench for the fan supervisor sequencing
`timescale 1ns/10ps
module tb;
  localparam int C = 256;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] tl = 8'h00;
  logic [7:0] ml = 8'h80;
  logic sns;
  logic sd = 1'b1;
  logic rl = 1'b0;
  logic ot = 1'b0;
  logic spin = 1'b0;
  logic drv;
  logic fo;
  logic foe;
  int fail_count = 0;
  int cmp_count = 0;
  int n;
  int lows;

  always #25 clk = ~clk;

  fsfs_top #(.PWM_STEP_CLKS(1), .BLANK_CLKS(8)) i_dut (.MCLK(clk),
    .RST_N(rst_n), .TEMP_CONTROL_LEVEL(tl), .MIN_SPEED_LEVEL(ml),
    .SENSE_PULSE(sns), .SHUTDOWN_CMP(sd), .RELEASE_CMP(rl),
    .OVERTEMP_CMP(ot), .FAN_DRIVE_OUT(drv), .FAULT_N_O(fo),
    .FAULT_N_OE(foe));
  fsfs_fan_model i_fan (.clk(clk), .drive(drv), .spin_en(spin),
    .sense(sns));

  task automatic chk_bit(string s, logic e, logic g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask : chk_bit

  task automatic chk_num(string s, int lo, int hi, int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      fail_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask : chk_num

  task automatic tick(int k);
    repeat (k) @(negedge clk);
  endtask : tick

  task automatic to_fault(logic v, int lim);
    n = 0;
    lows = 0;
    while (foe !== v && n < lim)
    begin
      tick(1);
      n++;
      lows += (drv !== 1'b1);
    end
  endtask : to_fault

  // Longer than any run duty below full level can keep the drive high
  task automatic to_solid(int lim);
    int run;
    run = 0;
    n = 0;
    while (run < 300 && n < lim)
    begin
      tick(1);
      n++;
      run = (drv === 1'b1) ? run + 1 : 0;
    end
  endtask : to_solid

  task automatic duty(int exp);
    int hi;
    hi = 0;
    repeat (4 * C)
    begin
      tick(1);
      hi += (drv === 1'b1);
    end
    chk_num("duty", 4 * exp - 8, 4 * exp + 8, hi);
  endtask : duty

  task automatic shdn_pulse();
    sd = 1'b1;
    rl = 1'b0;
    tick(10);
    sd = 1'b0;
    rl = 1'b1;
  endtask : shdn_pulse

  task automatic t_power_up();
    tick(20);
    sd = 1'b0;
    tick(100);
    chk_bit("drive held", 1'b0, drv);
    rl = 1'b1;
    to_fault(1'b1, 70 * C);
    chk_num("start fault time", 62 * C, 64 * C + 20, n);
    chk_num("start drive gaps", 0, 12, lows);
    // Drive drops one clock after the fault pin is pulled
    tick(1);
    chk_bit("fault drive", 1'b0, drv);
    tick(3 * C);
    chk_bit("latched drive", 1'b0, drv);
    chk_bit("latched pin", 1'b1, foe);
  endtask : t_power_up

  task automatic t_clear();
    spin = 1'b1;
    shdn_pulse();
    to_fault(1'b0, 20);
    chk_num("fault clear", 0, 8, n);
    tick(4 * C);
    tl = 8'h40;
    duty(128);
    tl = 8'hc0;
    ml = 8'h20;
    tick(C);
    duty(192);
    chk_bit("run pin", 1'b0, foe);
  endtask : t_clear

  task automatic t_overtemp();
    tl = 8'hff;
    ot = 1'b1;
    tick(C);
    chk_bit("overtemp pin", 1'b1, foe);
    duty(C);
    ot = 1'b0;
    tl = 8'h00;
    ml = 8'h80;
    tick(20);
    chk_bit("overtemp clear", 1'b0, foe);
  endtask : t_overtemp

  task automatic t_missing();
    tick(2 * C);
    spin = 1'b0;
    to_solid(40 * C);
    chk_num("missing timeout", 31 * C - 128, 33 * C + 300, n);
    spin = 1'b1;
    tick(4 * C);
    duty(128);
    spin = 1'b0;
    to_fault(1'b1, 75 * C);
    chk_num("retry fault time", 64 * C - 256, 68 * C, n);
    tick(1);
    chk_bit("retry drive", 1'b0, drv);
  endtask : t_missing

  task automatic t_restart();
    shdn_pulse();
    tick(20 * C);
    shdn_pulse();
    to_fault(1'b1, 70 * C);
    chk_num("restart fault time", 62 * C, 64 * C + 20, n);
    chk_num("restart gaps", 0, 12, lows);
  endtask : t_restart

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    tick(3);
    rst_n = 1'b1;
    t_power_up();
    t_clear();
    t_overtemp();
    t_missing();
    t_restart();
    give_verdict();
  end

  // Run needs about 70k clocks
  initial
  begin
    tick(95000);
    fail_count++;
    give_verdict();
  end
endmodule : tb
